// ---- rtl/gpw_pkg.sv ----
// Purpose: Constants and types for the bus write strobe and latch timer
// Assumes: Byte wide register port addressed by register offset
// Notes:   Every timing field counts internal clock periods, value plus one
//
// Behaviour
// - A write strobe stays active for its pulse length plus one clocks.
// - Write strobes rise write delay plus one clocks after cycle start.
// - The latch pulse stays active for its length field plus one clocks.
// - The latch pulse rises its delay plus one clocks after cycle start.
// - I/O and memory write strobes share one length and one delay setting.
// - Latch delay counts from each cycle start and resets to zero.
package gpw_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int          ADDR_W          = 12;
    localparam int          FIELD_W         = 8;
    localparam int          CNT_W           = 10;
    localparam logic [11:0] OFF_WR_LEN      = 12'h0c0d;
    localparam logic [11:0] OFF_WR_DELAY    = 12'h0c0e;
    localparam logic [11:0] OFF_ALE_LEN     = 12'h0c0f;
    localparam logic [11:0] OFF_ALE_DELAY   = 12'h0c10;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  RST_WR_LEN      = 8'h00;
    localparam logic [7:0]  RST_WR_DELAY    = 8'h00;
    localparam logic [7:0]  RST_ALE_LEN     = 8'h00;
    localparam logic [7:0]  RST_ALE_DELAY   = 8'h00;
    localparam logic [7:0]  RDATA_NONE      = 8'h00;

    // Timing fields travel together
    typedef struct packed {
        logic [7:0] write_pulse_len_field;
        logic [7:0] write_delay_field;
        logic [7:0] latch_pulse_len_field;
        logic [7:0] latch_delay_field;
    } gpw_timing_t;

    // Bus cycle request from the cycle generator
    typedef struct packed {
        logic start;
        logic is_write;
        logic is_mem;
    } gpw_cyc_t;

    typedef enum logic {
        GPW_IDLE,
        GPW_RUN
    } gpw_state_t;

endpackage

// ---- rtl/gpw_strobe_timer.sv ----
// Purpose: Places write strobes and the address latch pulse in a bus cycle
// Assumes: Inputs synchronous to core_clk, single clock domain
// Notes:   New cycle start is ignored while cyc_ready is low
`timescale 1ns/1ps
module gpw_strobe_timer (
    input  wire logic                      core_clk,
    input  wire logic                      arst_n,
    input  wire logic [gpw_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [7:0]                reg_wdata,
    output logic      [7:0]                reg_rdata,
    input  wire gpw_pkg::gpw_cyc_t         cyc,
    output logic                           cyc_ready,
    output logic                           io_write_strobe,
    output logic                           mem_write_strobe,
    output logic                           addr_latch_pulse_out
);
    import gpw_pkg::*;

    // ****************************************
    // Software registers
    // ****************************************
    gpw_timing_t regs_q;
    gpw_timing_t regs_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    // Byte lookup shared by read path
    function automatic logic [7:0] reg_read(input logic [11:0] a,
                                            input gpw_timing_t r);
        logic [7:0] v;
        v = RDATA_NONE;
        unique case (a)
            OFF_WR_LEN:    v = r.write_pulse_len_field;
            OFF_WR_DELAY:  v = r.write_delay_field;
            OFF_ALE_LEN:   v = r.latch_pulse_len_field;
            OFF_ALE_DELAY: v = r.latch_delay_field;
            default:       v = RDATA_NONE;
        endcase
        return v;
    endfunction

    // Register writes and registered read data; unmapped reads give zero
    always_comb begin
        regs_d  = regs_q;
        rdata_d = rdata_q;
        if (reg_wr) begin
            unique case (reg_addr)
                OFF_WR_LEN:    regs_d.write_pulse_len_field = reg_wdata;
                OFF_WR_DELAY:  regs_d.write_delay_field     = reg_wdata;
                OFF_ALE_LEN:   regs_d.latch_pulse_len_field = reg_wdata;
                OFF_ALE_DELAY: regs_d.latch_delay_field     = reg_wdata;
                default:       regs_d = regs_q;
            endcase
        end
        if (reg_rd) begin
            rdata_d = reg_read(reg_addr, regs_q);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            regs_q.write_pulse_len_field <= RST_WR_LEN;
            regs_q.write_delay_field     <= RST_WR_DELAY;
            regs_q.latch_pulse_len_field <= RST_ALE_LEN;
            regs_q.latch_delay_field     <= RST_ALE_DELAY;
            rdata_q                      <= RDATA_NONE;
        end else begin
            regs_q  <= regs_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // Cycle sequencer
    // ****************************************
    gpw_state_t             state_q;
    gpw_state_t             state_d;
    gpw_timing_t            lat_q;
    gpw_timing_t            lat_d;
    logic [CNT_W-1:0]       cnt_q;
    logic [CNT_W-1:0]       cnt_d;
    logic                   wr_q;
    logic                   wr_d;
    logic                   mem_q;
    logic                   mem_d;
    logic                   io_q;
    logic                   io_d;
    logic                   memwr_q;
    logic                   memwr_d;
    logic                   ale_q;
    logic                   ale_d;
    logic                   ready_q;
    logic                   ready_d;
    logic [CNT_W-1:0]       wr_rise;
    logic [CNT_W-1:0]       wr_last;
    logic [CNT_W-1:0]       ale_rise;
    logic [CNT_W-1:0]       ale_last;
    logic                   wr_win;
    logic                   ale_win;

    // Edges of each window, in clocks counted from the start edge
    always_comb begin
        wr_rise  = CNT_W'(lat_q.write_delay_field) + CNT_W'(1);
        wr_last  = wr_rise + CNT_W'(lat_q.write_pulse_len_field);
        ale_rise = CNT_W'(lat_q.latch_delay_field) + CNT_W'(1);
        ale_last = ale_rise + CNT_W'(lat_q.latch_pulse_len_field);
    end

    // Counter restarts at each taken start; fields latched only then
    always_comb begin
        state_d = state_q;
        lat_d   = lat_q;
        cnt_d   = cnt_q;
        wr_d    = wr_q;
        mem_d   = mem_q;
        wr_win  = 1'b0;
        ale_win = 1'b0;
        unique case (state_q)
            GPW_IDLE: begin
                if (cyc.start) begin
                    state_d = GPW_RUN;
                    lat_d   = regs_q;
                    cnt_d   = '0;
                    wr_d    = cyc.is_write;
                    mem_d   = cyc.is_mem;
                end
            end
            GPW_RUN: begin
                cnt_d   = cnt_q + CNT_W'(1);
                wr_win  = (cnt_d >= wr_rise) && (cnt_d <= wr_last);
                ale_win = (cnt_d >= ale_rise) && (cnt_d <= ale_last);
                // Cycle ends once both windows have closed
                if (cnt_d > wr_last && cnt_d > ale_last) begin
                    state_d = GPW_IDLE;
                    wr_win  = 1'b0;
                    ale_win = 1'b0;
                end
            end
        endcase
        // One window drives whichever strobe the cycle selected
        io_d    = wr_win && wr_q && !mem_q;
        memwr_d = wr_win && wr_q && mem_q;
        ale_d   = ale_win;
        ready_d = (state_d == GPW_IDLE);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= GPW_IDLE;
            lat_q   <= '0;
            cnt_q   <= '0;
            wr_q    <= 1'b0;
            mem_q   <= 1'b0;
            io_q    <= 1'b0;
            memwr_q <= 1'b0;
            ale_q   <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            lat_q   <= lat_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            mem_q   <= mem_d;
            io_q    <= io_d;
            memwr_q <= memwr_d;
            ale_q   <= ale_d;
            ready_q <= ready_d;
        end
    end

    assign reg_rdata            = rdata_q;
    assign cyc_ready            = ready_q;
    assign io_write_strobe      = io_q;
    assign mem_write_strobe     = memwr_q;
    assign addr_latch_pulse_out = ale_q;

    // ****************************************
    // Checks
    // ****************************************
    logic [CNT_W-1:0] wr_hi_q;
    logic [CNT_W-1:0] ale_hi_q;
    logic             ale_wrote_q;
    logic             any_wr;

    // Helper: high-time counters and first-write flag
    assign any_wr = io_q || memwr_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_hi_q     <= '0;
            ale_hi_q    <= '0;
            ale_wrote_q <= 1'b0;
        end else begin
            wr_hi_q  <= any_wr ? wr_hi_q + CNT_W'(1) : '0;
            ale_hi_q <= ale_q ? ale_hi_q + CNT_W'(1) : '0;
            if (reg_wr && reg_addr == OFF_ALE_DELAY) begin
                ale_wrote_q <= 1'b1;
            end
        end
    end

    sequence s_taken;
        state_q == GPW_IDLE && cyc.start;
    endsequence

    a_wr_width: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(any_wr) |-> wr_hi_q == wr_last - wr_rise + CNT_W'(1))
        else $error("write strobe width wrong");
    a_wr_rise_time: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(any_wr) |-> cnt_q == wr_rise)
        else $error("write strobe rose at wrong time");
    a_ale_width: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(ale_q) |-> ale_hi_q == ale_last - ale_rise + CNT_W'(1))
        else $error("latch pulse width wrong");
    a_ale_first_rise: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        s_taken ##1 (lat_q.latch_delay_field == 8'h00)
        |-> ##1 ale_q)
        else $error("latch pulse late for zero delay");
    a_strobe_shared: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !(io_q && memwr_q) && (!any_wr || wr_q))
        else $error("write strobes not exclusive");
    a_ale_reset_zero: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !ale_wrote_q |-> regs_q.latch_delay_field == 8'h00)
        else $error("latch delay not zero after reset");
    a_fields_held: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == GPW_RUN) ##1 (state_q == GPW_RUN)
        |-> $stable(lat_q))
        else $error("timing changed mid cycle");

endmodule

// ---- tb/gpw_periph_model.sv ----
// Purpose: Peripheral side observer of the latch and write strobes
// Assumes: Strobes are active high levels synchronous to core_clk
// Notes:   Reports rise offset from cycle start and width, in clocks
`timescale 1ns/1ps
module gpw_periph_model (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire gpw_pkg::gpw_cyc_t cyc,
    input  wire logic              cyc_ready,
    input  wire logic [2:0]        lvl,
    output logic      [2:0]        ev,
    output logic      [2:0][9:0]   ev_off,
    output logic      [2:0][9:0]   ev_len
);
    import gpw_pkg::*;
    logic [2:0][9:0] hi_q;
    logic [2:0][9:0] off_q;
    logic [9:0]      cnt_q;

    // Width is only known once a strobe drops, so report on the fall
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= '0;
            hi_q   <= '0;
            off_q  <= '0;
            ev     <= '0;
            ev_off <= '0;
            ev_len <= '0;
        end else begin
            if (cyc.start && cyc_ready) begin
                cnt_q <= 10'd1;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q + 10'd1;
            end
            for (int i = 0; i < 3; i++) begin
                ev[i] <= !lvl[i] && (hi_q[i] != '0);
                if (lvl[i]) begin
                    hi_q[i] <= hi_q[i] + 10'd1;
                    if (hi_q[i] == '0) begin
                        off_q[i] <= cnt_q - 10'd1; // Sample lags one clock
                    end
                end else if (hi_q[i] != '0) begin
                    ev_off[i] <= off_q[i];
                    ev_len[i] <= hi_q[i];
                    hi_q[i]   <= '0;
                end
            end
        end
    end
endmodule

// ---- tb/test_gpw_strobe_timer.sv ----
// Purpose: Self-checking bench for the write strobe and latch timer
// Assumes: Fields are latched when a cycle start is accepted
// Notes:   Expectations queue up per strobe and per register read
`timescale 1ns/1ps
module test_gpw_strobe_timer;
    import gpw_pkg::*;
    logic              core_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [11:0]       reg_addr = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        reg_wdata = '0;
    logic [7:0]        reg_rdata;
    gpw_cyc_t          cyc = '0;
    logic              cyc_ready;
    logic              io_write_strobe;
    logic              mem_write_strobe;
    logic              addr_latch_pulse_out;
    logic [2:0]        ev;
    logic [2:0][9:0]   ev_off;
    logic [2:0][9:0]   ev_len;
    logic [19:0]       eq [3][$];
    logic [19:0]       rq [$];
    logic [7:0]        f [4];
    logic              rd_seen = 1'b0;
    logic [19:0]       want;
    int                bad_count = 0;
    int                n_compared = 0;

    always #5 core_clk = ~core_clk;

    gpw_strobe_timer i_gpw_strobe_timer (.core_clk(core_clk),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cyc(cyc), .cyc_ready(cyc_ready), .io_write_strobe(io_write_strobe),
        .mem_write_strobe(mem_write_strobe),
        .addr_latch_pulse_out(addr_latch_pulse_out));
    gpw_periph_model i_gpw_periph_model (.core_clk(core_clk),
        .arst_n(arst_n), .cyc(cyc), .cyc_ready(cyc_ready),
        .lvl({mem_write_strobe, io_write_strobe, addr_latch_pulse_out}),
        .ev(ev), .ev_off(ev_off), .ev_len(ev_len));

    // ****************************************
    // Checking
    // ****************************************
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Counts: %0d compared, %0d wrong", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Oldest note is matched against each result; strays hit all ones
    always @(posedge core_clk) begin
        if (rd_seen) begin
            want = rq.size() ? rq.pop_front() : '1;
            check({12'h000, reg_rdata}, want);
        end
        rd_seen = reg_rd;
        for (int i = 0; i < 3; i++) begin
            if (ev[i]) begin
                want = eq[i].size() ? eq[i].pop_front() : '1;
                if (i == 0) begin
                    check({ev_off[i], ev_len[i]}, want);
                end else begin
                    check({ev_off[i], ev_len[i]}, want);
                end
            end
        end
    end

    // ****************************************
    // Drivers
    // ****************************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        rq.push_back({12'h000, d});
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
    endtask

    // Start accepted one edge later; a stray start follows while busy
    task automatic cyc_go(input logic w, input logic m);
        do @(negedge core_clk); while (cyc_ready !== 1'b1);
        eq[0].push_back({10'(f[3]) + 10'd1, 10'(f[2]) + 10'd1});
        if (w) eq[m ? 2 : 1].push_back({10'(f[1]) + 10'd1, 10'(f[0]) + 10'd1});
        @(posedge core_clk);
        cyc <= '{start: 1'b1, is_write: w, is_mem: m};
        @(posedge core_clk);
        cyc <= '0;
        // Busy must show from the taking edge on, before the stray start
        @(negedge core_clk);
        check(20'(cyc_ready), '0);
        @(posedge core_clk);
        cyc <= '{start: 1'b1, is_write: 1'b1, is_mem: !m};
        @(posedge core_clk);
        cyc <= '0;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        void'($urandom(32'h0565efd5));
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int j = 0; j < 4; j++) rd(OFF_WR_LEN + 12'(j), 8'h00);
        wr(12'h0c11, 8'h5a);
        rd(12'h0c11, 8'h00);
        // Fields are rewritten while the previous cycle still runs
        for (int k = 0; k < 14; k++) begin
            for (int j = 0; j < 4; j++) begin
                f[j] = (k == 1) ? 8'hff : (k == 0) ? 8'h00
                                                    : 8'($urandom_range(0, 6));
                wr(OFF_WR_LEN + 12'(j), f[j]);
            end
            rd(OFF_WR_LEN + 12'(k % 4), f[k % 4]);
            cyc_go(k % 3 != 2, k % 3 == 1);
        end
        do @(negedge core_clk); while (cyc_ready !== 1'b1);
        repeat (4) @(posedge core_clk);
        check(20'(eq[0].size() + eq[1].size() + eq[2].size() + rq.size()),
              '0);
        close_out();
    end

    // Whole run needs a few thousand clocks at most
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        close_out();
    end
endmodule
